// File: vfs_pkg.sv
package vfs_pkg;
  // Sync transitions from vertical start to line 14
  localparam int TRANS_TO_LINE14 = 16;
  localparam int FIRST_LINE = 14;
  // Offset added to the wanted line number
  localparam logic [7:0] SELECT_OFFSET = 8'h02;
  // Transitions spanning one line (two edges per line)
  localparam logic [1:0] EDGES_PER_LINE = 2'h2;
  // Back porch gate time and clock rate
  localparam int PORCH_NS = 4000;
  localparam int CLK_PERIOD_NS = 8;
  // Least time, so round up
  localparam int PORCH_CYCLES = (PORCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Reset values
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // Idle pin levels: syncs high, porch high, field low
  localparam logic [3:0] PINS_IDLE = 4'he;
  localparam logic [1:0] SEL_VERTICAL = 2'h0;
  localparam logic [1:0] SEL_EVEN = 2'h1;
  localparam logic [1:0] SEL_ODD = 2'h2;

  typedef enum logic [1:0] {
    VFS_IDLE = 2'b00,
    VFS_COUNT = 2'b01,
    VFS_GATE = 2'b10
  } vfs_state_type;
endpackage

// File: vfs_sync2.sv
`timescale 1ns/100ps
module vfs_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } vfs_sync_type;

  vfs_sync_type s_r;
  vfs_sync_type s_nxt;

  if (WIDTH < 1) begin : g_width_bad
    $error("vfs_sync2: WIDTH must be at least 1");
  end

  // First stage feeds only the second
  always_comb begin
    s_nxt.meta = async_in;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // Idle levels, so no false edge follows reset
      s_r.meta <= RESET_VALUE;
      s_r.stable <= RESET_VALUE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.stable;
endmodule

// File: vfs_line_selector.sv
`timescale 1ns/100ps
// Function
// - Sixteenth sync transition after vertical start begins line 14.
// - Select value is the wanted line number plus two, eight bits.
// - Trigger falling edge loads counter and sets the start latch.
// - Count sync transitions while latched; final borrow opens line gate.
// - Falling edge of line gate clears the start latch.
// - Vertical trigger gives one line per field; field index trigger gives one per frame.
// - Field index trigger selects one field; invert for odd field.
// - Counter width matches line range; eight bits here.
// - Extended selector gates a run of adjoining lines.
// - Outside the selected lines, output holds sampled black level.
module vfs_line_selector #(
  parameter int SEL_WIDTH = 8,
  parameter int RUN_WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Separator outputs, asynchronous pins
  input wire logic csync_n_pin,
  input wire logic vsync_n_pin,
  input wire logic porch_n_pin,
  input wire logic field_pin,
  // Selection controls
  input wire logic [SEL_WIDTH-1:0] line_select_bits,
  input wire logic [RUN_WIDTH-1:0] run_lines,
  input wire logic [1:0] trigger_select,
  // Video switch controls
  output logic line_gate,
  output logic black_clamp,
  output logic field_odd,
  output logic vertical_seen
);
  typedef struct packed {
    vfs_pkg::vfs_state_type state;
    logic [SEL_WIDTH-1:0] count;
    logic [RUN_WIDTH-1:0] run_left;
    logic [1:0] line_edges;
    logic start_latch;
    logic csync_d;
    logic trig_d;
    logic gate;
    logic clamp;
    logic odd;
    logic vseen;
  } vfs_sel_type;

  vfs_sel_type s_r;
  vfs_sel_type s_nxt;
  logic [3:0] pins_s;
  logic csync_s;
  logic vsync_s;
  logic porch_s;
  logic field_s;
  logic trig_lvl;
  logic sync_edge;
  logic trig_fall;

  if (SEL_WIDTH < 4 || SEL_WIDTH > 16) begin : g_sel_bad
    $error("vfs_line_selector: SEL_WIDTH out of range");
  end
  if (RUN_WIDTH < 1 || RUN_WIDTH > 16) begin : g_run_bad
    $error("vfs_line_selector: RUN_WIDTH out of range");
  end

  // Pins come from the analog separator clock domain
  vfs_sync2 #(.WIDTH(4), .RESET_VALUE(vfs_pkg::PINS_IDLE)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({csync_n_pin, vsync_n_pin, porch_n_pin, field_pin}),
    .sync_out(pins_s)
  );

  assign csync_s = pins_s[3];
  assign vsync_s = pins_s[2];
  assign porch_s = pins_s[1];
  assign field_s = pins_s[0];

  // Trigger source; vertical pin is active low, pulse is high here
  always_comb begin
    unique case (trigger_select)
      vfs_pkg::SEL_EVEN: trig_lvl = field_s;
      vfs_pkg::SEL_ODD: trig_lvl = ~field_s;
      default: trig_lvl = ~vsync_s;
    endcase
  end

  // Both polarities of composite sync count
  assign sync_edge = csync_s ^ s_r.csync_d;
  assign trig_fall = s_r.trig_d & ~trig_lvl;

  always_comb begin
    s_nxt = s_r;
    s_nxt.csync_d = csync_s;
    s_nxt.trig_d = trig_lvl;
    s_nxt.odd = field_s;
    s_nxt.vseen = ~vsync_s;
    // Black level is sampled while the porch gate is low and the line gate is closed
    s_nxt.clamp = ~porch_s & ~s_r.gate;
    unique case (s_r.state)
      vfs_pkg::VFS_IDLE: begin
        s_nxt.gate = 1'b0;
      end
      vfs_pkg::VFS_COUNT: begin
        if (sync_edge && s_r.start_latch) begin
          if (s_r.count == '0) begin
            // Borrow: gate opens for the selected line
            s_nxt.gate = 1'b1;
            s_nxt.line_edges = 2'h0;
            s_nxt.state = vfs_pkg::VFS_GATE;
          end else begin
            s_nxt.count = s_r.count - 1'b1;
          end
        end
      end
      vfs_pkg::VFS_GATE: begin
        if (sync_edge) begin
          if (s_r.line_edges == vfs_pkg::EDGES_PER_LINE - 2'h1) begin
            if (s_r.run_left == '0) begin
              // Gate falls, so the latch is released
              s_nxt.gate = 1'b0;
              s_nxt.start_latch = 1'b0;
              s_nxt.state = vfs_pkg::VFS_IDLE;
            end else begin
              // Adjoining lines keep the gate open
              s_nxt.run_left = s_r.run_left - 1'b1;
              s_nxt.line_edges = 2'h0;
            end
          end else begin
            s_nxt.line_edges = s_r.line_edges + 2'h1;
          end
        end
      end
      default: begin
        s_nxt.state = vfs_pkg::VFS_IDLE;
        s_nxt.gate = 1'b0;
      end
    endcase
    // Retrigger wins over any count in flight
    if (trig_fall) begin
      // Value is wanted line plus two; an eight bit counter fits 253
      s_nxt.count = line_select_bits - 1'b1;
      s_nxt.run_left = run_lines;
      s_nxt.start_latch = 1'b1;
      s_nxt.line_edges = 2'h0;
      s_nxt.gate = 1'b0;
      s_nxt.state = vfs_pkg::VFS_COUNT;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r.state <= vfs_pkg::VFS_IDLE;
      s_r.count <= '0;
      s_r.run_left <= '0;
      s_r.line_edges <= 2'h0;
      s_r.start_latch <= 1'b0;
      s_r.csync_d <= 1'b1;
      s_r.trig_d <= 1'b0;
      s_r.gate <= 1'b0;
      s_r.clamp <= 1'b0;
      s_r.odd <= 1'b0;
      s_r.vseen <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign line_gate = s_r.gate;
  assign black_clamp = s_r.clamp;
  assign field_odd = s_r.odd;
  assign vertical_seen = s_r.vseen;
endmodule

// File: vfs_props.sv
`timescale 1ns/100ps
module vfs_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins
  input wire logic csync_n_pin,
  input wire logic vsync_n_pin,
  input wire logic porch_n_pin,
  input wire logic field_pin,
  // Controls
  input wire logic [7:0] line_select_bits,
  input wire logic [7:0] run_lines,
  input wire logic [1:0] trigger_select,
  // Outputs
  input wire logic line_gate,
  input wire logic black_clamp,
  input wire logic field_odd,
  input wire logic vertical_seen
);
  logic c_r, t_r, d_r;
  logic [7:0] m_r;
  logic [8:0] n_r;
  // Pin-side counts; same lag as the design on both ends
  wire tg = trigger_select == 2'h1 ? field_pin :
    trigger_select == 2'h2 ? !field_pin : !vsync_n_pin;
  wire ce = c_r != csync_n_pin;
  wire tf = t_r && !tg;
  always_ff @(posedge clk) begin
    c_r <= csync_n_pin;
    t_r <= tg;
    m_r <= reset || tf ? 8'h00 : m_r + {7'h00, ce};
    n_r <= line_gate ? n_r + {8'h00, ce} : 9'h000;
    d_r <= !reset && !tf && (d_r || $fell(line_gate));
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_gate_opens: assert property (
    $rose(line_gate) |-> m_r == line_select_bits) else $error("open");
  a_gate_length: assert property (
    $fell(line_gate) |-> n_r == {run_lines, 1'b0} + 9'h002) else $error("len");
  a_rise_edge: assert property (
    $rose(line_gate) |-> $past(csync_n_pin, 1) != $past(csync_n_pin, 8))
    else $error("rise");
  a_fall_edge: assert property (
    $fell(line_gate) |-> $past(csync_n_pin, 1) != $past(csync_n_pin, 8))
    else $error("fall");
  a_one_gate: assert property (
    d_r |-> !$rose(line_gate)) else $error("again");
  a_clamp_gate: assert property (
    line_gate && $past(line_gate) |-> !black_clamp) else $error("clamp");
  a_vert_seen: assert property (
    $fell(vsync_n_pin) |-> ##[1:5] vertical_seen) else $error("vert");
  a_field_follow: assert property (
    $changed(field_pin) |-> ##[1:5] field_odd == field_pin) else $error("fld");
endmodule

// File: vfs_src.sv
`timescale 1ns/100ps
module vfs_src (
  // Clock
  input wire logic clk,
  // Separator pins
  output logic csync_n_pin,
  output logic vsync_n_pin,
  output logic porch_n_pin,
  output logic field_pin
);
  initial {csync_n_pin, vsync_n_pin, porch_n_pin, field_pin} = 4'he;
  // Edges kept far apart so none is lost in synchronisers
  task automatic flip();
    csync_n_pin = !csync_n_pin;
    repeat (csync_n_pin ? vfs_pkg::PORCH_CYCLES + 16 : 16) @(negedge clk);
  endtask
  always @(posedge csync_n_pin) begin
    porch_n_pin = 1'b0;
    repeat (vfs_pkg::PORCH_CYCLES) @(negedge clk);
    porch_n_pin = 1'b1;
  end
  task automatic vert(input logic odd);
    field_pin = odd;
    vsync_n_pin = 1'b0;
    repeat (8) @(negedge clk);
    vsync_n_pin = 1'b1;
    repeat (16) @(negedge clk);
  endtask
endmodule

// File: tb.sv
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic reset, csync_n_pin, vsync_n_pin, porch_n_pin, field_pin;
  logic [7:0] line_select_bits, run_lines;
  logic [1:0] trigger_select;
  logic line_gate, black_clamp, field_odd, vertical_seen;
  int failures, n_checks, e;
  // Trigger select, select value, extra lines
  logic [17:0] rows[5] = '{18'h01000, 18'h00100, 18'h10500, 18'h20402,
    18'h30301};
  vfs_src u_src (
    .clk(clk),
    .csync_n_pin(csync_n_pin),
    .vsync_n_pin(vsync_n_pin),
    .porch_n_pin(porch_n_pin),
    .field_pin(field_pin)
  );
  vfs_line_selector u_dut (
    .clk(clk),
    .reset(reset),
    .csync_n_pin(csync_n_pin),
    .vsync_n_pin(vsync_n_pin),
    .porch_n_pin(porch_n_pin),
    .field_pin(field_pin),
    .line_select_bits(line_select_bits),
    .run_lines(run_lines),
    .trigger_select(trigger_select),
    .line_gate(line_gate),
    .black_clamp(black_clamp),
    .field_odd(field_odd),
    .vertical_seen(vertical_seen)
  );
  task automatic chk(input string nm, input logic got, input logic x);
    n_checks++;
    if (got !== x) begin
      failures++;
      $display("Error %s expected %b seen %b", nm, x, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    forever #4 clk = ~clk;
  end
  // Some three and a half times the planned run
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    {trigger_select, line_select_bits, run_lines} = 18'h0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    foreach (rows[i]) begin
      {trigger_select, line_select_bits, run_lines} = rows[i];
      e = line_select_bits + 2 * run_lines + 2;
      u_src.vert(trigger_select == 2'h1);
      u_src.vert(trigger_select != 2'h1);
      chk("field_odd", field_odd, trigger_select != 2'h1);
      for (int k = 1; k <= e + 2; k++) begin
        u_src.flip();
        chk("gate", line_gate, k >= line_select_bits && k < e);
      end
    end
    // Reset in mid-gate must close it
    {trigger_select, line_select_bits, run_lines} = 18'h00200;
    u_src.vert(1'b0);
    u_src.vert(1'b1);
    u_src.flip();
    u_src.flip();
    chk("gate", line_gate, 1'b1);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    chk("reset gate", line_gate, 1'b0);
    reset = 1'b0;
    // No trigger pending after release, so edges must be ignored
    repeat (3) @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      fork
        u_src.flip();
        begin
          repeat (10) @(negedge clk);
          chk("black_clamp", black_clamp, u_src.csync_n_pin);
        end
      join
      chk("gate after reset", line_gate, 1'b0);
    end
    fork
      u_src.vert(1'b1);
      begin
        repeat (5) @(negedge clk);
        chk("vertical_seen", vertical_seen, 1'b1);
      end
    join
    chk("vertical_seen", vertical_seen, 1'b0);
    // Selection resumes: select 2, single line
    for (int k = 1; k <= 4; k++) begin
      u_src.flip();
      chk("gate after reset", line_gate, k >= 2 && k < 4);
    end
    complete_run();
  end
endmodule
bind vfs_line_selector vfs_props u_props (
  .clk(clk),
  .reset(reset),
  .csync_n_pin(csync_n_pin),
  .vsync_n_pin(vsync_n_pin),
  .porch_n_pin(porch_n_pin),
  .field_pin(field_pin),
  .line_select_bits(line_select_bits),
  .run_lines(run_lines),
  .trigger_select(trigger_select),
  .line_gate(line_gate),
  .black_clamp(black_clamp),
  .field_odd(field_odd),
  .vertical_seen(vertical_seen)
);
